// [rtl/gts_pkg.sv]
// Overview of operation
// [RQ1] gain mode is fixed high, fixed low or automatic; fixed high after reset
// [RQ2] threshold, population and hysteresis values matter only in automatic gain mode
// [RQ3] a pixel is hot above the intensity threshold, percent of full scale, default 90
// [RQ4] high-to-low is wanted when hot pixel share reaches its population, default 5
// [RQ5] low-to-high is wanted when cool pixel share reaches its population, default 98
// [RQ6] low-to-high population below 100 minus high-to-low population is refused
// [RQ7] cool threshold derives from intensity threshold and hysteresis, default 95
// [RQ8] cool threshold equals hysteresis percent times the hot intensity threshold
// [RQ9] hot and cool shares are evaluated once per frame over all pixels
// [RQ10] active table reads 0 in low gain and 1 to 3 in high gain
// [RQ11] target table follows ambient temperature, scene statistics and gain settings
// [RQ12] high gain tables: 1 below -20C, 2 up to 60C, 3 above
// [RQ13] automatic gain with automatic flat-field switches whenever target differs
// [RQ14] manual or external flat-field mode switches only on a host table command
// [RQ15] in those modes a wanted drop to low gain shows pending with target 0
// [RQ16] switching from table 0 enters high gain, switching to table 0 low gain
// [RQ17] a table command is ignored while target equals active table
// [RQ18] pending is set when target differs from active, never in automatic flat-field
// [RQ19] by default a ring marks the flat-field symbol while a switch is pending
// [RQ20] an option lets external flat-field mode switch tables automatically
// [RQ21] active, target and pending are readable on telemetry and by status read
// [RQ22] every gain switch pulses a reset of the noise filters
// [RQ23] consumer grade has no gain modes and always stays in high gain
// [RQ24] settings can be saved as power-on defaults and factory values restored; reset loads factory values, saved ones load only on a load command
// [RQ25] in automatic flat-field mode a table change triggers a flat-field correction
package gts_pkg;
    localparam logic [1:0] GAIN_HIGH = 2'h0;
    localparam logic [1:0] GAIN_LOW  = 2'h1;
    localparam logic [1:0] GAIN_AUTO = 2'h2;
    localparam logic [1:0] FFC_AUTO  = 2'h0;
    localparam logic [1:0] FFC_MAN   = 2'h1;
    localparam logic [1:0] FFC_EXT   = 2'h2;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_HOTTHR = 8'h04;
    localparam logic [7:0] OFS_HLPOP  = 8'h08;
    localparam logic [7:0] OFS_LHPOP  = 8'h0C;
    localparam logic [7:0] OFS_HYST   = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CMD    = 8'h18;

    // control word fields
    localparam int CTRL_GAIN_LSB = 0;
    localparam int CTRL_FFC_LSB  = 2;
    localparam int CTRL_EXTAUTO  = 4;
    localparam int CTRL_RING     = 5;
    // command word bits
    localparam int CMD_SWITCH  = 0;
    localparam int CMD_SAVE    = 1;
    localparam int CMD_FACTORY = 2;
    localparam int CMD_LOAD    = 3;
    // status word fields
    localparam int STAT_ACT_LSB = 0;
    localparam int STAT_TGT_LSB = 2;
    localparam int STAT_PEND    = 4;
    localparam int STAT_HIGH    = 5;

    localparam logic [6:0] PCT_FULL     = 7'h64;
    localparam logic [6:0] DEF_HOTTHR   = 7'h5A;
    localparam logic [6:0] DEF_HLPOP    = 7'h05;
    localparam logic [6:0] DEF_LHPOP    = 7'h62;
    localparam logic [6:0] DEF_HYST     = 7'h5F;
    localparam logic [15:0] PIX_FULL    = 16'hFFFF;
    localparam logic [13:0] PCT_SQUARED = 14'h2710;
    localparam logic signed [7:0] TEMP_T1_T2 = -8'sd20;
    localparam logic signed [7:0] TEMP_T2_T3 = 8'sd60;
    localparam logic [1:0] TBL_LOW = 2'h0;
    localparam logic [1:0] TBL_1   = 2'h1;
    localparam logic [1:0] TBL_2   = 2'h2;
    localparam logic [1:0] TBL_3   = 2'h3;

    typedef struct packed {
        logic [1:0] gain_mode;
        logic [1:0] ffc_mode;
        logic       ext_auto;
        logic       ring_en;
        logic [6:0] hot_thr;
        logic [6:0] hl_pop;
        logic [6:0] lh_pop;
        logic [6:0] hyst;
    } gts_cfg_type;

    localparam gts_cfg_type CFG_FACTORY = '{gain_mode: GAIN_HIGH, ffc_mode: FFC_AUTO,
        ext_auto: 1'b0, ring_en: 1'b1, hot_thr: DEF_HOTTHR, hl_pop: DEF_HLPOP,
        lh_pop: DEF_LHPOP, hyst: DEF_HYST};

    typedef struct packed {
        logic [1:0] active;
        logic [1:0] target;
        logic       pending;
    } gts_telem_type;
endpackage : gts_pkg

// [rtl/gts_selector.sv]
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module gts_selector #(
    parameter int  CNT_W          = 20,
    parameter bit  CONSUMER_GRADE = 1'b0
) (
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_N,
    input  wire logic                   HSEL,
    input  wire logic [31:0]            HADDR,
    input  wire logic [1:0]             HTRANS,
    input  wire logic                   HWRITE,
    input  wire logic [2:0]             HSIZE,
    input  wire logic [31:0]            HWDATA,
    input  wire logic                   HREADY,
    output logic      [31:0]            HRDATA,
    output logic                        HREADYOUT,
    output logic                        HRESP,
    input  wire logic                   PIX_VALID,
    input  wire logic [15:0]            PIX_DATA,
    input  wire logic                   FRAME_END,
    input  wire logic signed [7:0]      AMBIENT_TEMP,
    output gts_pkg::gts_telem_type      TELEM_STATUS,
    output logic                        GAIN_IS_HIGH,
    output logic                        RING_OVERLAY,
    output logic                        FFC_TRIGGER,
    output logic                        FILTER_RESET
);
    typedef struct packed {
        gts_pkg::gts_cfg_type cfg;
        gts_pkg::gts_cfg_type saved;
        logic [1:0]           active;
        logic [1:0]           target;
        logic                 pending;
        logic                 want_low;
        logic                 want_high;
        logic [CNT_W-1:0]     hot_cnt;
        logic [CNT_W-1:0]     cool_cnt;
        logic [CNT_W-1:0]     tot_cnt;
        logic                 wr_pend;
        logic [7:0]           waddr;
        logic [31:0]          rdata;
        logic                 ring;
        logic                 ffc_trig;
        logic                 filt_rst;
    } gts_state_type;

    // counters below 8 bits cannot hold a useful frame, above 24 the share products need more than 31 bits
    if (CNT_W < 8 || CNT_W > 24) begin : g_bad_cnt_w
        $error("CNT_W out of range");
    end

    gts_state_type st_reg;
    gts_state_type st_next;

    logic [22:0]      pix_scaled;
    logic [22:0]      hot_limit;
    logic [29:0]      pix_scaled2;
    logic [29:0]      cool_limit;
    logic             pix_hot;
    logic             pix_cool;
    logic [1:0]       temp_table;
    logic             auto_sw;
    logic             differ;
    logic             sw_cmd;
    logic [CNT_W+6:0] hot_share;
    logic [CNT_W+6:0] hot_need;
    logic [CNT_W+6:0] cool_share;
    logic [CNT_W+6:0] cool_need;
    logic [31:0]      wd;

    // pixel scoring against both thresholds, all in percent of full scale
    always_comb begin
        pix_scaled  = 23'(PIX_DATA) * 23'(gts_pkg::PCT_FULL);
        hot_limit   = 23'(st_reg.cfg.hot_thr) * 23'(gts_pkg::PIX_FULL);
        pix_hot     = pix_scaled > hot_limit;                                         // RQ3
        pix_scaled2 = 30'(PIX_DATA) * 30'(gts_pkg::PCT_SQUARED);
        cool_limit  = 30'(st_reg.cfg.hyst) * 30'(st_reg.cfg.hot_thr)
                      * 30'(gts_pkg::PIX_FULL);                                       // RQ7 RQ8
        pix_cool    = pix_scaled2 < cool_limit;
        hot_share   = (CNT_W+7)'(st_reg.hot_cnt) * (CNT_W+7)'(gts_pkg::PCT_FULL);
        hot_need    = (CNT_W+7)'(st_reg.tot_cnt) * (CNT_W+7)'(st_reg.cfg.hl_pop);
        cool_share  = (CNT_W+7)'(st_reg.cool_cnt) * (CNT_W+7)'(gts_pkg::PCT_FULL);
        cool_need   = (CNT_W+7)'(st_reg.tot_cnt) * (CNT_W+7)'(st_reg.cfg.lh_pop);
    end

    always_comb begin
        if (AMBIENT_TEMP < gts_pkg::TEMP_T1_T2) begin                                 // RQ12
            temp_table = gts_pkg::TBL_1;
        end else if (AMBIENT_TEMP <= gts_pkg::TEMP_T2_T3) begin
            temp_table = gts_pkg::TBL_2;
        end else begin
            temp_table = gts_pkg::TBL_3;
        end
    end

    assign auto_sw = (st_reg.cfg.ffc_mode == gts_pkg::FFC_AUTO)                       // RQ13
                     || (st_reg.cfg.ffc_mode == gts_pkg::FFC_EXT && st_reg.cfg.ext_auto); // RQ20
    assign differ  = st_reg.target != st_reg.active;
    assign wd      = HWDATA;
    assign sw_cmd  = st_reg.wr_pend && st_reg.waddr == gts_pkg::OFS_CMD
                     && wd[gts_pkg::CMD_SWITCH];

    always_comb begin
        st_next          = st_reg;
        st_next.ffc_trig = 1'b0;
        st_next.filt_rst = 1'b0;
        st_next.wr_pend  = 1'b0;

        // write data phase
        if (st_reg.wr_pend) begin
            if (st_reg.waddr == gts_pkg::OFS_CTRL) begin
                st_next.cfg.gain_mode = wd[gts_pkg::CTRL_GAIN_LSB +: 2];
                st_next.cfg.ffc_mode  = wd[gts_pkg::CTRL_FFC_LSB +: 2];
                st_next.cfg.ext_auto  = wd[gts_pkg::CTRL_EXTAUTO];
                st_next.cfg.ring_en   = wd[gts_pkg::CTRL_RING];
            end else if (st_reg.waddr == gts_pkg::OFS_HOTTHR) begin
                if (wd[6:0] <= gts_pkg::PCT_FULL) begin
                    st_next.cfg.hot_thr = wd[6:0];
                end
            end else if (st_reg.waddr == gts_pkg::OFS_HLPOP) begin
                if (wd[6:0] <= gts_pkg::PCT_FULL) begin
                    st_next.cfg.hl_pop = wd[6:0];
                end
            end else if (st_reg.waddr == gts_pkg::OFS_LHPOP) begin
                // a too-small value would let the scene flip the gain every frame
                if (wd[6:0] <= gts_pkg::PCT_FULL
                    && wd[6:0] >= gts_pkg::PCT_FULL - st_reg.cfg.hl_pop) begin        // RQ6
                    st_next.cfg.lh_pop = wd[6:0];
                end
            end else if (st_reg.waddr == gts_pkg::OFS_HYST) begin
                if (wd[6:0] <= gts_pkg::PCT_FULL) begin
                    st_next.cfg.hyst = wd[6:0];
                end
            end else if (st_reg.waddr == gts_pkg::OFS_CMD) begin
                if (wd[gts_pkg::CMD_SAVE]) begin
                    st_next.saved = st_reg.cfg;                                       // RQ24
                end else if (wd[gts_pkg::CMD_FACTORY]) begin
                    st_next.cfg = gts_pkg::CFG_FACTORY;                               // RQ24
                end else if (wd[gts_pkg::CMD_LOAD]) begin
                    st_next.cfg = st_reg.saved;
                end
            end
        end

        // address phase; reads answer with zero wait states
        if (HSEL && HTRANS[1] && HREADY) begin
            st_next.wr_pend = HWRITE;
            st_next.waddr   = HADDR[7:0];
            if (!HWRITE) begin
                st_next.rdata = 32'h0000_0000;
                if (HADDR[7:0] == gts_pkg::OFS_CTRL) begin
                    st_next.rdata[gts_pkg::CTRL_GAIN_LSB +: 2] = st_reg.cfg.gain_mode;
                    st_next.rdata[gts_pkg::CTRL_FFC_LSB +: 2]  = st_reg.cfg.ffc_mode;
                    st_next.rdata[gts_pkg::CTRL_EXTAUTO]       = st_reg.cfg.ext_auto;
                    st_next.rdata[gts_pkg::CTRL_RING]          = st_reg.cfg.ring_en;
                end else if (HADDR[7:0] == gts_pkg::OFS_HOTTHR) begin
                    st_next.rdata[6:0] = st_reg.cfg.hot_thr;
                end else if (HADDR[7:0] == gts_pkg::OFS_HLPOP) begin
                    st_next.rdata[6:0] = st_reg.cfg.hl_pop;
                end else if (HADDR[7:0] == gts_pkg::OFS_LHPOP) begin
                    st_next.rdata[6:0] = st_reg.cfg.lh_pop;
                end else if (HADDR[7:0] == gts_pkg::OFS_HYST) begin
                    st_next.rdata[6:0] = st_reg.cfg.hyst;
                end else if (HADDR[7:0] == gts_pkg::OFS_STATUS) begin
                    st_next.rdata[gts_pkg::STAT_ACT_LSB +: 2] = st_reg.active;        // RQ21
                    st_next.rdata[gts_pkg::STAT_TGT_LSB +: 2] = st_reg.target;
                    st_next.rdata[gts_pkg::STAT_PEND]         = st_reg.pending;
                    st_next.rdata[gts_pkg::STAT_HIGH]         = st_reg.active != gts_pkg::TBL_LOW;
                end
            end
        end

        // frame statistics; the pixel of a frame-end cycle opens the next frame
        if (FRAME_END) begin
            if (st_reg.tot_cnt != '0) begin                                           // RQ9
                st_next.want_low  = hot_share >= hot_need;                            // RQ4
                st_next.want_high = cool_share >= cool_need;                          // RQ5
            end
            st_next.hot_cnt  = CNT_W'(PIX_VALID && pix_hot);
            st_next.cool_cnt = CNT_W'(PIX_VALID && pix_cool);
            st_next.tot_cnt  = CNT_W'(PIX_VALID);
        end else if (PIX_VALID && st_reg.tot_cnt != '1) begin
            st_next.hot_cnt  = st_reg.hot_cnt + CNT_W'(pix_hot);
            st_next.cool_cnt = st_reg.cool_cnt + CNT_W'(pix_cool);
            st_next.tot_cnt  = st_reg.tot_cnt + CNT_W'(1'b1);
        end

        // target table
        if (CONSUMER_GRADE) begin
            st_next.target = temp_table;                                              // RQ23
        end else begin
            case (st_reg.cfg.gain_mode)                                               // RQ11
                gts_pkg::GAIN_LOW:  st_next.target = gts_pkg::TBL_LOW;
                gts_pkg::GAIN_AUTO: begin
                    if (st_reg.active != gts_pkg::TBL_LOW) begin                      // RQ2
                        st_next.target = st_reg.want_low ? gts_pkg::TBL_LOW : temp_table;
                    end else begin
                        st_next.target = st_reg.want_high ? temp_table : gts_pkg::TBL_LOW;
                    end
                end
                default: st_next.target = temp_table;                                 // RQ1
            endcase
        end

        // switching; a command with no difference does nothing
        if (differ && (auto_sw || sw_cmd)) begin                                      // RQ14 RQ17
            st_next.active   = st_reg.target;                                         // RQ16
            st_next.ffc_trig = st_reg.cfg.ffc_mode == gts_pkg::FFC_AUTO;              // RQ25
            st_next.filt_rst = (st_reg.active == gts_pkg::TBL_LOW)
                               != (st_reg.target == gts_pkg::TBL_LOW);                // RQ22
        end
        st_next.pending = differ && !auto_sw && !sw_cmd;                              // RQ15 RQ18
        st_next.ring    = st_next.pending && st_reg.cfg.ring_en;                      // RQ19
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            st_reg        <= '0;
            st_reg.cfg    <= gts_pkg::CFG_FACTORY;                                    // RQ1
            st_reg.saved  <= gts_pkg::CFG_FACTORY;
            st_reg.active <= gts_pkg::TBL_2;
            st_reg.target <= gts_pkg::TBL_2;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            HREADYOUT <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
        end
    end

    assign HRDATA       = st_reg.rdata;
    assign HRESP        = 1'b0;
    assign TELEM_STATUS = '{active: st_reg.active, target: st_reg.target,
                            pending: st_reg.pending};                                 // RQ21
    assign GAIN_IS_HIGH = st_reg.active != gts_pkg::TBL_LOW;                          // RQ10
    assign RING_OVERLAY = st_reg.ring;
    assign FFC_TRIGGER  = st_reg.ffc_trig;
    assign FILTER_RESET = st_reg.filt_rst;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    a_gain_mode_default: assert property (
        !$past(RST_N) |-> st_reg.cfg.gain_mode == gts_pkg::GAIN_HIGH) // RQ1
        else $error("gain mode not high after reset");

    a_fixed_high_target: assert property (
        st_reg.cfg.gain_mode == gts_pkg::GAIN_HIGH |=> st_reg.target == $past(temp_table)) // RQ2
        else $error("fixed high mode target not temperature table");

    a_lhpop_refused: assert property (
        st_reg.wr_pend && st_reg.waddr == gts_pkg::OFS_LHPOP
        && HWDATA[6:0] < gts_pkg::PCT_FULL - st_reg.cfg.hl_pop
        |=> $stable(st_reg.cfg.lh_pop)) // RQ6
        else $error("low-to-high population accepted below limit");

    a_pending_flag: assert property (
        differ && !auto_sw && !sw_cmd |=> TELEM_STATUS.pending) // RQ18
        else $error("pending flag missing");

    a_no_pending_auto: assert property (
        st_reg.cfg.ffc_mode == gts_pkg::FFC_AUTO ##1 st_reg.cfg.ffc_mode == gts_pkg::FFC_AUTO
        |-> !TELEM_STATUS.pending) // RQ18
        else $error("pending set in automatic flat-field mode");

    a_cmd_equal_ignored: assert property (
        sw_cmd && !differ |=> $stable(st_reg.active)) // RQ17
        else $error("table changed on command with no difference");

    a_auto_switch: assert property (
        auto_sw && differ |=> TELEM_STATUS.active == $past(st_reg.target)
        ##1 (!FFC_TRIGGER || $past(differ))) // RQ13
        else $error("automatic switch missing");

    a_ffc_on_change: assert property (
        $changed(st_reg.active) && $past(st_reg.cfg.ffc_mode) == gts_pkg::FFC_AUTO
        |-> FFC_TRIGGER) // RQ25
        else $error("no flat-field trigger on table change");

    a_filter_reset: assert property (
        $changed(GAIN_IS_HIGH) |-> FILTER_RESET) // RQ22
        else $error("gain switch without filter reset");

    a_consumer_high: assert property (!CONSUMER_GRADE || GAIN_IS_HIGH) // RQ23
        else $error("consumer grade left high gain");
endmodule : gts_selector

// [tb/gts_host.sv]
`timescale 1ns/100ps
module gts_host (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // single word transfer; no wait count assumed, only the bench timeout ends a hang
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h00_0000, addr};
        hsize  <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        haddr  <= ~{24'h00_0000, addr};
        hwdata <= wr ? wd : ~hwdata;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        // released data lines must not keep showing the last value
        hwdata <= ~wd;
    endtask : xfer

    task automatic switch_if_pending(output logic done);
        logic [31:0] st;
        xfer(1'b0, gts_pkg::OFS_STATUS, 32'h0000_0000, st);
        done = st[gts_pkg::STAT_PEND];
        if (done === 1'b1) begin
            xfer(1'b1, gts_pkg::OFS_CMD, 32'h0000_0001, st);
        end
    endtask : switch_if_pending
endmodule : gts_host

// [tb/gts_selector_tb.sv]
`timescale 1ns/100ps
module gts_selector_tb;
    logic                  ref_clk;
    logic                  rst_n;
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [2:0]            hsize;
    logic [31:0]           hwdata;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  pix_valid;
    logic [15:0]           pix_data;
    logic                  frame_end;
    logic signed [7:0]     ambient_temp;
    gts_pkg::gts_telem_type telem;
    logic                  gain_is_high;
    logic                  ring_overlay;
    logic                  ffc_trigger;
    logic                  filter_reset;
    logic [31:0]           rd;
    logic                  done;
    logic                  hresp;
    logic                  gain_high_cg;
    int                    n_errors = 0;
    int                    checked = 0;
    int                    n_ffc = 0;
    int                    n_frst = 0;
    int                    cycles = 0;

    gts_selector i_gts_selector (.REF_CLK(ref_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PIX_VALID(pix_valid),
        .PIX_DATA(pix_data), .FRAME_END(frame_end), .AMBIENT_TEMP(ambient_temp),
        .TELEM_STATUS(telem), .GAIN_IS_HIGH(gain_is_high), .RING_OVERLAY(ring_overlay),
        .FFC_TRIGGER(ffc_trigger), .FILTER_RESET(filter_reset));
    // consumer grade copy sees the same bus writes and scenes but must never leave high gain
    gts_selector #(.CONSUMER_GRADE(1'b1)) i_gts_selector_cg (.REF_CLK(ref_clk), .RST_N(rst_n),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(), .HREADYOUT(), .HRESP(),
        .PIX_VALID(pix_valid), .PIX_DATA(pix_data), .FRAME_END(frame_end),
        .AMBIENT_TEMP(ambient_temp), .TELEM_STATUS(), .GAIN_IS_HIGH(gain_high_cg),
        .RING_OVERLAY(), .FFC_TRIGGER(), .FILTER_RESET());
    gts_host i_gts_host (.clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (ffc_trigger === 1'b1) n_ffc++;
        if (filter_reset === 1'b1) n_frst++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic final_report;
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_gts_host.xfer(1'b1, a, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        i_gts_host.xfer(1'b0, a, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask : rd_chk

    task automatic chk_state(input logic [1:0] act, input logic [1:0] tgt, input logic pend);
        rd_chk(gts_pkg::OFS_STATUS, {26'h000_0000, act != 2'h0, pend, tgt, act});
        chk({27'h000_0000, telem}, {27'h000_0000, act, tgt, pend});
        chk({31'h0000_0000, gain_is_high}, {31'h0000_0000, act != 2'h0});
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
        chk({31'h0000_0000, gain_high_cg}, 32'h0000_0001);
    endtask : chk_state

    // pixel values stand exactly on the hot and cool boundaries of the default settings
    task automatic frame(input logic [15:0] a, input int na, input logic [15:0] b, input int nb);
        for (int i = 0; i < na + nb; i++) begin
            @(posedge ref_clk);
            pix_valid <= 1'b1;
            pix_data  <= (i < na) ? a : b;
        end
        @(posedge ref_clk);
        pix_valid <= 1'b0;
        pix_data  <= ~pix_data;
        frame_end <= 1'b1;
        @(posedge ref_clk);
        frame_end <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask : frame

    task automatic t_reset;
        chk_state(2'h2, 2'h2, 1'b0);
        rd_chk(gts_pkg::OFS_CTRL, 32'h0000_0020);
        rd_chk(gts_pkg::OFS_HOTTHR, 32'h0000_005A);
        rd_chk(gts_pkg::OFS_HLPOP, 32'h0000_0005);
        rd_chk(gts_pkg::OFS_LHPOP, 32'h0000_0062);
        rd_chk(gts_pkg::OFS_HYST, 32'h0000_005F);
        wr(8'h40, 32'h0000_00FF);
        rd_chk(8'h40, 32'h0000_0000);
    endtask : t_reset

    task automatic t_fixed;
        frame(16'hFFFF, 20, 16'h0000, 0);
        chk_state(2'h2, 2'h2, 1'b0);
        wr(gts_pkg::OFS_CTRL, 32'h0000_0021);
        frame(16'h0000, 0, 16'h0000, 0);
        chk_state(2'h0, 2'h0, 1'b0);
    endtask : t_fixed

    task automatic t_auto_hl;
        int f0;
        int r0;
        wr(gts_pkg::OFS_CTRL, 32'h0000_0020);
        // a cool frame first, so no hot verdict of an earlier frame is left standing
        frame(16'h0000, 20, 16'h0000, 0);
        wr(gts_pkg::OFS_CTRL, 32'h0000_0022);
        f0 = n_ffc;
        r0 = n_frst;
        frame(16'hE665, 1, 16'h0000, 19);
        chk_state(2'h2, 2'h2, 1'b0);
        frame(16'hFFFF, 1, 16'h0000, 20);
        chk_state(2'h2, 2'h2, 1'b0);
        frame(16'hE666, 1, 16'h0000, 19);
        chk_state(2'h0, 2'h0, 1'b0);
        chk(n_ffc - f0, 32'h0000_0001);
        chk(n_frst - r0, 32'h0000_0001);
    endtask : t_auto_hl

    task automatic t_auto_lh;
        frame(16'hDAE0, 48, 16'hDAE1, 2);
        chk_state(2'h0, 2'h0, 1'b0);
        frame(16'hDAE0, 49, 16'hDAE1, 1);
        chk_state(2'h2, 2'h2, 1'b0);
    endtask : t_auto_lh

    task automatic t_manual;
        int f0;
        wr(gts_pkg::OFS_CTRL, 32'h0000_0026);
        f0 = n_ffc;
        frame(16'hFFFF, 20, 16'h0000, 0);
        chk_state(2'h2, 2'h0, 1'b1);
        chk({31'h0000_0000, ring_overlay}, 32'h0000_0001);
        i_gts_host.switch_if_pending(done);
        chk({31'h0000_0000, done}, 32'h0000_0001);
        chk_state(2'h0, 2'h0, 1'b0);
        chk({31'h0000_0000, ring_overlay}, 32'h0000_0000);
        wr(gts_pkg::OFS_CMD, 32'h0000_0001);
        chk_state(2'h0, 2'h0, 1'b0);
        chk(n_ffc - f0, 32'h0000_0000);
    endtask : t_manual

    task automatic t_ext;
        wr(gts_pkg::OFS_CTRL, 32'h0000_003A);
        frame(16'h0000, 20, 16'h0000, 0);
        chk_state(2'h2, 2'h2, 1'b0);
        wr(gts_pkg::OFS_CTRL, 32'h0000_002A);
        frame(16'hFFFF, 20, 16'h0000, 0);
        chk_state(2'h2, 2'h0, 1'b1);
    endtask : t_ext

    task automatic t_temps;
        logic [7:0] tv[4] = '{8'hEB, 8'hEC, 8'h3C, 8'h3D};
        logic [1:0] ev[4] = '{2'h1, 2'h2, 2'h2, 2'h3};
        wr(gts_pkg::OFS_CTRL, 32'h0000_0020);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            ambient_temp <= tv[i];
            frame(16'h0000, 0, 16'h0000, 0);
            chk_state(ev[i], ev[i], 1'b0);
        end
    endtask : t_temps

    task automatic t_limits;
        wr(gts_pkg::OFS_LHPOP, 32'h0000_005E);
        rd_chk(gts_pkg::OFS_LHPOP, 32'h0000_0062);
        wr(gts_pkg::OFS_LHPOP, 32'h0000_005F);
        rd_chk(gts_pkg::OFS_LHPOP, 32'h0000_005F);
        wr(gts_pkg::OFS_HOTTHR, 32'h0000_0065);
        rd_chk(gts_pkg::OFS_HOTTHR, 32'h0000_005A);
    endtask : t_limits

    task automatic t_defaults;
        wr(gts_pkg::OFS_HOTTHR, 32'h0000_0050);
        wr(gts_pkg::OFS_CMD, 32'h0000_0002);
        wr(gts_pkg::OFS_HOTTHR, 32'h0000_0046);
        wr(gts_pkg::OFS_CMD, 32'h0000_0004);
        rd_chk(gts_pkg::OFS_HOTTHR, 32'h0000_005A);
        wr(gts_pkg::OFS_CMD, 32'h0000_0008);
        rd_chk(gts_pkg::OFS_HOTTHR, 32'h0000_0050);
    endtask : t_defaults

    initial begin
        rst_n        = 1'b0;
        pix_valid    = 1'b0;
        pix_data     = 16'h0000;
        frame_end    = 1'b0;
        ambient_temp = 8'h19;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_fixed();
        t_auto_hl();
        t_auto_lh();
        t_manual();
        t_ext();
        t_temps();
        t_limits();
        t_defaults();
        final_report();
    end
endmodule : gts_selector_tb
